// ---- logic/spsm_pkg.sv ----
// Constants, register map and state codes for the serial port select-mode block.
package spsm_pkg;
  localparam int DATA_W     = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int ADDR_W     = 4;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_DATA = 4'h8;
  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_EN_BIT   = 0;
  localparam int CTRL_MST_BIT  = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_WCOL_BIT = 1;
  localparam int STAT_MODE_FAULT_FLAG_BIT = 2;
  localparam int STAT_OVR_BIT  = 3;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_RXF_BIT  = 5;
  localparam logic [1:0] SEL_3WIRE  = 2'h0;
  localparam logic [1:0] SEL_INPUT  = 2'h1;
  localparam logic [1:0] MODE_RST   = 2'h1;
  localparam logic [3:0] BITS_BYTE  = 4'h8;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SYS_PERIOD_NS  = 40;
  localparam int LINK_PERIOD_NS = 320;
  localparam int HALF_CYC       = LINK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam logic [2:0] HALF_LAST = 3'(HALF_CYC - 1);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_LOW  = 3'b010,
    ST_HIGH = 3'b100
  } spsm_state_t;
endpackage

// ---- logic/spsm_fifo_if.sv ----
// Valid/ready carrier between the port logic and its transmit FIFO.
`timescale 1ns/10ps
interface spsm_fifo_if;
  logic       push_valid;
  logic       push_ready;
  logic [7:0] push_data;
  logic       pop_valid;
  logic       pop_ready;
  logic [7:0] pop_data;
  modport user (output push_valid, push_data, pop_ready,
                input push_ready, pop_valid, pop_data);
  modport fifo (input push_valid, push_data, pop_ready,
                output push_ready, pop_valid, pop_data);
endinterface

// ---- logic/spsm_fifo.sv ----
// Transmit FIFO with parameterised width and depth.
`timescale 1ns/10ps
module spsm_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic ce,
  spsm_fifo_if.fifo f
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } spsm_fifo_st_t;
  spsm_fifo_st_t   s_ff;
  spsm_fifo_st_t   nxt_s;
  logic [W-1:0]    mem [D];
  logic            full;
  logic            empty;
  logic            do_push;
  logic            do_pop;
  always_comb begin
    empty   = s_ff.wp == s_ff.rp;
    full    = (s_ff.wp[AW] != s_ff.rp[AW]) && (s_ff.wp[AW-1:0] == s_ff.rp[AW-1:0]);
    do_push = f.push_valid && !full;
    do_pop  = f.pop_ready && !empty;
    nxt_s   = s_ff;
    if (do_push) begin
      nxt_s.wp = s_ff.wp + 1'b1;
    end
    if (do_pop) begin
      nxt_s.rp = s_ff.rp + 1'b1;
    end
  end
  assign f.push_ready = !full;
  assign f.pop_valid  = !empty;
  assign f.pop_data   = mem[s_ff.rp[AW-1:0]];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_ff <= '0;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (ce && do_push && !rst) begin
      mem[s_ff.wp[AW-1:0]] <= f.push_data;
    end
  end
endmodule

// ---- logic/spsm_port.sv ----
// Serial port with pin direction control and slave-select mode logic.
// Operation
// - Port works as master or slave, 3-wire or 4-wire, shared bus.
// - Master-to-slave line is output as master, input as slave.
// - As master, master-to-slave line carries shift register MSB first.
// - Slave-to-master line is input as master, output as slave, MSB first.
// - Slave-to-master line floats when disabled or unselected 4-wire slave.
// - As 3-wire slave, slave-to-master line always carries shift register MSB.
// - Only the master drives the serial clock; slaves receive it.
// - Unselected 4-wire slave ignores all serial clock activity.
// - Mode 00: select unused, slave always selected, single slave on bus.
// - Mode 01: select is an input; low selects a slave.
// - Mode 01 master: select falling edge disables the master function.
// - Mode 1x: select is an output equal to the mode low bit.
// - Select pin is unmapped in mode 00, mapped otherwise.
// - Master data write fills buffer; empty shifter starts transfer, done flag at end.
// - Multi-master select falling edge clears master and port enables, sets mode fault.
// - 4-wire slave clears its bit counter on each select falling edge.
`timescale 1ns/10ps
module spsm_port
  import spsm_pkg::*;
(
  input  wire logic                         sys_clk,
  input  wire logic                         rst,
  input  wire logic                         ce,
  input  wire logic [spsm_pkg::ADDR_W-1:0]  addr,
  input  wire logic [spsm_pkg::DATA_W-1:0]  wdata,
  input  wire logic                         wr_stb,
  input  wire logic                         rd_stb,
  output logic      [spsm_pkg::DATA_W-1:0]  rdata,
  input  wire logic                         sck_in,
  output logic                              sck_out,
  output logic                              sck_oe,
  input  wire logic                         mosi_in,
  output logic                              mosi_out,
  output logic                              mosi_oe,
  input  wire logic                         miso_in,
  output logic                              miso_out,
  output logic                              miso_oe,
  input  wire logic                         slave_select_n_in,
  output logic                              slave_select_n_out,
  output logic                              slave_select_n_oe,
  output logic                              select_pin_mapped
);
  import spsm_pkg::*;
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic        mst;
    logic [1:0]  mode;
    logic        done;
    logic        wcol;
    logic        mode_fault_flag;
    logic        ovr;
    logic [7:0]  sr;
    logic        sr_full;
    logic        smp;
    logic [3:0]  cnt;
    spsm_state_t st;
    logic [2:0]  div;
    logic [7:0]  rx;
    logic        rxf;
    logic [7:0]  rdata;
    logic        sck_m, sck_s, sck_p;
    logic        nss_m, nss_s, nss_p;
    logic        mosi_m, mosi_s;
    logic        miso_m, miso_s;
    logic        sck_o, sck_oe;
    logic        mosi_o, mosi_oe;
    logic        miso_o, miso_oe;
    logic        nss_o, nss_oe, nss_map;
  } spsm_state_reg_t;
  spsm_state_reg_t s_ff;
  spsm_state_reg_t nxt_s;
  spsm_fifo_if     txf ();
  logic            push;
  logic            take;
  spsm_fifo #(
    .W (DATA_W),
    .D (FIFO_DEPTH)
  ) u_txfifo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .ce      (ce),
    .f       (txf)
  );
  assign txf.push_valid = push;
  assign txf.push_data  = wdata;
  assign txf.pop_ready  = take;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic sck_rise;
    logic sck_fall;
    logic nss_fall;
    logic sel;
    logic slv;
    logic byte_end;
    logic [7:0] shifted;
    sck_rise = s_ff.sck_s && !s_ff.sck_p;
    sck_fall = !s_ff.sck_s && s_ff.sck_p;
    nss_fall = s_ff.nss_p && !s_ff.nss_s;
    sel      = (s_ff.mode == SEL_3WIRE) || (s_ff.mode == SEL_INPUT && !s_ff.nss_s);
    slv      = s_ff.en && !s_ff.mst;
    byte_end = 1'b0;
    shifted  = {s_ff.sr[6:0], s_ff.smp};
    push     = 1'b0;
    take     = 1'b0;
    nxt_s    = s_ff;
    nxt_s.rdata  = '0;
    nxt_s.sck_m  = sck_in;
    nxt_s.sck_s  = s_ff.sck_m;
    nxt_s.sck_p  = s_ff.sck_s;
    nxt_s.nss_m  = slave_select_n_in;
    nxt_s.nss_s  = s_ff.nss_m;
    nxt_s.nss_p  = s_ff.nss_s;
    nxt_s.mosi_m = mosi_in;
    nxt_s.mosi_s = s_ff.mosi_m;
    nxt_s.miso_m = miso_in;
    nxt_s.miso_s = s_ff.miso_m;
    // ----------------------------------------------------------------
    // Register bus
    // ----------------------------------------------------------------
    if (wr_stb) begin
      case (addr)
        ADDR_CTRL: begin
          nxt_s.en   = wdata[CTRL_EN_BIT];
          nxt_s.mst  = wdata[CTRL_MST_BIT];
          nxt_s.mode = wdata[CTRL_MODE_LSB +: 2];
        end
        ADDR_STAT: begin
          nxt_s.done = s_ff.done && !wdata[STAT_DONE_BIT];
          nxt_s.wcol = s_ff.wcol && !wdata[STAT_WCOL_BIT];
          nxt_s.mode_fault_flag = s_ff.mode_fault_flag && !wdata[STAT_MODE_FAULT_FLAG_BIT];
          nxt_s.ovr  = s_ff.ovr && !wdata[STAT_OVR_BIT];
        end
        ADDR_DATA: begin
          push = txf.push_ready;
          if (!txf.push_ready) begin
            nxt_s.wcol = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_stb) begin
      case (addr)
        ADDR_CTRL: nxt_s.rdata = {4'h0, s_ff.mode, s_ff.mst, s_ff.en};
        ADDR_STAT: nxt_s.rdata = {2'h0, s_ff.rxf, s_ff.st != ST_IDLE, s_ff.ovr,
                                  s_ff.mode_fault_flag, s_ff.wcol, s_ff.done};
        ADDR_DATA: begin
          nxt_s.rdata = s_ff.rx;
          nxt_s.rxf   = 1'b0;
        end
        default: nxt_s.rdata = '0;
      endcase
    end
    // ----------------------------------------------------------------
    // Master sequencer
    // ----------------------------------------------------------------
    case (s_ff.st)
      ST_IDLE: begin
        if (s_ff.en && s_ff.mst && txf.pop_valid) begin
          take        = 1'b1;
          nxt_s.sr    = txf.pop_data;
          nxt_s.cnt   = '0;
          nxt_s.div   = '0;
          nxt_s.st    = ST_LOW;
        end
      end
      ST_LOW: begin
        nxt_s.div = s_ff.div + 3'h1;
        if (s_ff.div == HALF_LAST) begin
          nxt_s.div   = '0;
          nxt_s.sck_o = 1'b1;
          nxt_s.smp   = s_ff.miso_s;
          nxt_s.st    = ST_HIGH;
        end
      end
      ST_HIGH: begin
        nxt_s.div = s_ff.div + 3'h1;
        if (s_ff.div == HALF_LAST) begin
          nxt_s.div   = '0;
          nxt_s.sck_o = 1'b0;
          nxt_s.sr    = shifted;
          nxt_s.cnt   = s_ff.cnt + 4'h1;
          nxt_s.st    = ST_LOW;
          if (s_ff.cnt == BITS_BYTE - 4'h1) begin
            nxt_s.st = ST_IDLE;
            byte_end = 1'b1;
          end
        end
      end
      default: nxt_s.st = ST_IDLE;
    endcase
    // ----------------------------------------------------------------
    // Slave shifter
    // ----------------------------------------------------------------
    if (slv && sel) begin
      if (sck_rise) begin
        nxt_s.smp = s_ff.mosi_s;
      end
      if (sck_fall) begin
        nxt_s.sr  = shifted;
        nxt_s.cnt = s_ff.cnt + 4'h1;
        if (s_ff.cnt == BITS_BYTE - 4'h1) begin
          nxt_s.cnt     = '0;
          nxt_s.sr_full = 1'b0;
          byte_end      = 1'b1;
        end
      end else if (!s_ff.sr_full && s_ff.cnt == 4'h0 && txf.pop_valid) begin
        take          = 1'b1;
        nxt_s.sr      = txf.pop_data;
        nxt_s.sr_full = 1'b1;
      end
    end
    if (slv && s_ff.mode == SEL_INPUT && nss_fall) begin
      nxt_s.cnt = '0;
    end
    // The 3-wire slave has no framing, so only disabling realigns its counter.
    if (!s_ff.en) begin
      nxt_s.cnt     = '0;
      nxt_s.sr_full = 1'b0;
    end
    if (byte_end) begin
      nxt_s.done = 1'b1;
      if (slv && s_ff.rxf && !(rd_stb && addr == ADDR_DATA)) begin
        nxt_s.ovr = 1'b1;
      end else begin
        nxt_s.rx  = shifted;
        nxt_s.rxf = 1'b1;
      end
    end
    // A lost master aborts its byte at once to keep off the other master's bus.
    if (s_ff.en && s_ff.mst && s_ff.mode == SEL_INPUT && nss_fall) begin
      nxt_s.en    = 1'b0;
      nxt_s.mst   = 1'b0;
      nxt_s.mode_fault_flag  = 1'b1;
      nxt_s.st    = ST_IDLE;
      nxt_s.sck_o = 1'b0;
    end
    // ----------------------------------------------------------------
    // Pin drivers
    // ----------------------------------------------------------------
    nxt_s.sck_oe  = s_ff.en && s_ff.mst;
    nxt_s.mosi_oe = s_ff.en && s_ff.mst;
    nxt_s.mosi_o  = s_ff.sr[7];
    nxt_s.miso_oe = slv && sel;
    nxt_s.miso_o  = s_ff.sr[7];
    nxt_s.nss_oe  = s_ff.mode[1];
    nxt_s.nss_o   = s_ff.mode[0];
    nxt_s.nss_map = s_ff.mode != SEL_3WIRE;
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_ff      <= '0;
      s_ff.mode <= MODE_RST;
      s_ff.st   <= ST_IDLE;
      s_ff.sck_m <= 1'b1;
      s_ff.sck_s <= 1'b0;
      s_ff.nss_m <= 1'b1;
      s_ff.nss_s <= 1'b1;
      s_ff.nss_p <= 1'b1;
      s_ff.nss_o <= 1'b1;
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end
  assign rdata              = s_ff.rdata;
  assign sck_out            = s_ff.sck_o;
  assign sck_oe             = s_ff.sck_oe;
  assign mosi_out           = s_ff.mosi_o;
  assign mosi_oe            = s_ff.mosi_oe;
  assign miso_out           = s_ff.miso_o;
  assign miso_oe            = s_ff.miso_oe;
  assign slave_select_n_out = s_ff.nss_o;
  assign slave_select_n_oe  = s_ff.nss_oe;
  assign select_pin_mapped  = s_ff.nss_map;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst || !ce);
  chk_mosi_dir: assert property ($past(s_ff.en && s_ff.mst) == mosi_oe)
    else $error("mosi direction wrong");
  chk_mosi_msb: assert property (mosi_oe |-> mosi_out == $past(s_ff.sr[7]))
    else $error("mosi not msb");
  chk_miso_float: assert property ((!s_ff.en || (!s_ff.mst && s_ff.mode == SEL_INPUT
    && s_ff.nss_s)) |=> !miso_oe) else $error("miso not floated");
  chk_miso_3wire: assert property ((s_ff.en && !s_ff.mst && s_ff.mode == SEL_3WIRE)
    |=> miso_oe && miso_out == $past(s_ff.sr[7])) else $error("3-wire miso not driven");
  chk_sck_owner: assert property (!(s_ff.en && s_ff.mst) |=> !sck_oe)
    else $error("sck driven as slave");
  chk_sck_ignore: assert property ((s_ff.en && !s_ff.mst && s_ff.mode == SEL_INPUT
    && s_ff.nss_s && s_ff.en) |=> s_ff.cnt == $past(s_ff.cnt) || !$past(nxt_s.en))
    else $error("sck not ignored");
  chk_mode_fault: assert property ((s_ff.en && s_ff.mst && s_ff.mode == SEL_INPUT
    && s_ff.nss_p && !s_ff.nss_s) |=> !s_ff.en && !s_ff.mst && s_ff.mode_fault_flag && s_ff.st == ST_IDLE)
    else $error("mode fault missed");
  chk_nss_out: assert property (s_ff.mode[1] |=> slave_select_n_oe
    && slave_select_n_out == $past(s_ff.mode[0])) else $error("select output wrong");
  chk_nss_map: assert property (1'b1 |=> select_pin_mapped == $past(s_ff.mode != SEL_3WIRE))
    else $error("select mapping wrong");
  chk_master_done: assert property ((s_ff.st == ST_IDLE ##1 s_ff.st == ST_LOW)
    |-> ##[60:70] (s_ff.done || !s_ff.mst)) else $error("master byte not done");
  chk_cnt_clear: assert property ((s_ff.en && !s_ff.mst && s_ff.mode == SEL_INPUT
    && s_ff.nss_p && !s_ff.nss_s) |=> s_ff.cnt == 4'h0) else $error("bit count kept");
  cov_master_byte: cover property (s_ff.mst && s_ff.st == ST_HIGH ##1 s_ff.st == ST_IDLE);
  cov_slave_byte: cover property (!s_ff.mst && !s_ff.done ##1 s_ff.done);
  cov_mode_fault: cover property (!s_ff.mode_fault_flag ##1 s_ff.mode_fault_flag);
endmodule

// ---- dv/spsm_link_partner.sv ----
// Far-side serial device model: answers as a slave or runs frames as a master, clock mode 0.
`timescale 1ns/10ps
module spsm_link_partner (
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso,
  output logic      p_sck,
  output logic      p_mosi,
  output logic      p_miso,
  output logic      p_ss_n
);
  logic [7:0] stx;
  logic [7:0] srx;
  logic [7:0] mrx;
  logic [7:0] rxq[$];
  logic [7:0] txq[$];
  int         cnt;
  bit         act_master;
  initial begin
    p_sck      = 1'h0;
    p_mosi     = 1'h0;
    p_miso     = 1'h0;
    p_ss_n     = 1'h1;
    cnt        = 0;
    stx        = 8'h00;
    act_master = 1'h0;
  end
  // ----------------------------------------------------------------
  // Slave role
  // ----------------------------------------------------------------
  task automatic start_slave();
    act_master = 1'h0;
    cnt        = 0;
    stx        = txq.pop_front();
    p_miso     = stx[7];
  endtask
  always @(posedge sck) begin
    if (!act_master) begin
      srx = {srx[6:0], mosi};
      cnt++;
    end
  end
  // The next bit changes only after a fall, so it stands over the sync delay of the master.
  always @(negedge sck) begin
    if (!act_master) begin
      if (cnt == 8) begin
        rxq.push_back(srx);
        cnt = 0;
        stx = (txq.size() > 0) ? txq.pop_front() : ~stx;
      end
      p_miso = stx[7-cnt];
    end
  end
  // ----------------------------------------------------------------
  // Master role
  // ----------------------------------------------------------------
  // Without sel the select line stays high, as on a 3-wire bus.
  task automatic frame(input logic [7:0] tx, input int nb, input bit sel);
    act_master = 1'h1;
    // Select stays high for several system clocks so the port sees each new frame.
    #167;
    if (sel) begin
      p_ss_n = 1'h0;
    end
    #200;
    for (int i = 0; i < nb; i++) begin
      p_mosi = tx[7-i];
      #160;
      p_sck  = 1'h1;
      p_miso = ~p_miso;
      #160;
      mrx    = {mrx[6:0], miso};
      p_sck  = 1'h0;
    end
    #200;
    p_ss_n = 1'h1;
    p_mosi = ~p_mosi;
  endtask
endmodule

// ---- dv/spi_pin_and_select_mode_logic_tb_top.sv ----
// Self-checking bench for the serial port pin and select-mode logic.
`timescale 1ns/10ps
module spi_pin_and_select_mode_logic_tb_top;
  import spsm_pkg::*;
  logic              sys_clk = 1'h0;
  logic              rst     = 1'h1;
  logic              ce      = 1'h1;
  logic [ADDR_W-1:0] addr    = 4'h0;
  logic [7:0]        wdata   = 8'h00;
  logic              wr_stb  = 1'h0;
  logic              rd_stb  = 1'h0;
  logic [7:0]        rdata;
  logic              sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe;
  logic              miso_in, miso_out, miso_oe, ss_in, ss_out, ss_oe, mapped;
  logic              p_sck, p_mosi, p_miso, p_ss_n;
  logic [7:0]        pins;
  logic [7:0]        b;
  logic [7:0]        v;
  logic [7:0]        exq[$];
  integer            seed;
  int                n_errors        = 0;
  int                samples_checked = 0;
  int                i;
  always #20 sys_clk = ~sys_clk;
  // Each pin level is the port's output when the port's enable is set, else the partner's output.
  assign sck_in  = sck_oe ? sck_out : p_sck;
  assign mosi_in = mosi_oe ? mosi_out : p_mosi;
  assign miso_in = miso_oe ? miso_out : p_miso;
  assign ss_in   = ss_oe ? ss_out : p_ss_n;
  assign pins    = {2'h0, sck_oe, mosi_oe, miso_oe, ss_oe, ss_out, mapped};
  spsm_port dut_u (.sys_clk(sys_clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .sck_in(sck_in), .sck_out(sck_out),
    .sck_oe(sck_oe), .mosi_in(mosi_in), .mosi_out(mosi_out), .mosi_oe(mosi_oe),
    .miso_in(miso_in), .miso_out(miso_out), .miso_oe(miso_oe), .slave_select_n_in(ss_in),
    .slave_select_n_out(ss_out), .slave_select_n_oe(ss_oe), .select_pin_mapped(mapped));
  spsm_link_partner partner_u (.sck(sck_in), .mosi(mosi_in), .miso(miso_in), .p_sck(p_sck),
    .p_mosi(p_mosi), .p_miso(p_miso), .p_ss_n(p_ss_n));
  // ----------------------------------------------------------------
  // Bus tasks and checks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      n_errors++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr   <= a;
    wdata  <= d;
    wr_stb <= 1'h1;
    @(posedge sys_clk);
    wr_stb <= 1'h0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [7:0] m, input logic [7:0] exp);
    @(posedge sys_clk);
    addr   <= a;
    rd_stb <= 1'h1;
    @(posedge sys_clk);
    rd_stb <= 1'h0;
    #1;
    chk(rdata & m, exp);
  endtask
  // Pin drivers are registered twice after the write, so they settle two cycles later.
  task automatic cfg(input logic [7:0] c, input logic [7:0] exp);
    wr(ADDR_CTRL, c);
    repeat (3) @(posedge sys_clk);
    #1;
    chk(pins, exp);
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #(40 * 30000);
    n_errors++;
    end_of_test();
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h3384;
    repeat (12) @(posedge sys_clk);
    rst <= 1'h0;
    rchk(ADDR_CTRL, 8'hFF, 8'h04);
    rchk(ADDR_STAT, 8'hFF, 8'h00);
    rchk(4'hC, 8'hFF, 8'h00);
    chk(pins, 8'h03);
    cfg(8'h00, 8'h00);
    for (i = 0; i < 33; i++) begin
      b = 8'($random(seed));
      if (i < 32) exq.push_back(b);
      if (i == 32) rchk(ADDR_STAT, 8'h02, 8'h00);
      wr(ADDR_DATA, b);
      partner_u.txq.push_back(8'($random(seed)));
    end
    rchk(ADDR_STAT, 8'h02, 8'h02);
    v = partner_u.txq[31];
    partner_u.start_slave();
    cfg(8'h03, 8'h30);
    for (i = 0; i < 4000 && partner_u.rxq.size() < 32; i++) @(posedge sys_clk);
    repeat (200) @(posedge sys_clk);
    chk(8'(partner_u.rxq.size()), 8'h20);
    for (i = 0; i < 32; i++) chk(partner_u.rxq[i], exq[i]);
    rchk(ADDR_STAT, 8'h01, 8'h01);
    rchk(ADDR_DATA, 8'hFF, v);
    wr(ADDR_STAT, 8'h0F);
    cfg(8'h05, 8'h03);
    b = 8'($random(seed));
    wr(ADDR_DATA, b);
    partner_u.frame(8'($random(seed)), 8, 1'h0);
    v = 8'($random(seed));
    partner_u.frame(v, 8, 1'h1);
    chk(partner_u.mrx, b);
    rchk(ADDR_DATA, 8'hFF, v);
    partner_u.frame(8'hFF, 3, 1'h1);
    v = 8'($random(seed));
    partner_u.frame(v, 8, 1'h1);
    rchk(ADDR_DATA, 8'hFF, v);
    b = 8'($random(seed));
    partner_u.frame(b, 8, 1'h1);
    partner_u.frame(8'($random(seed)), 8, 1'h1);
    rchk(ADDR_STAT, 8'h08, 8'h08);
    rchk(ADDR_DATA, 8'hFF, b);
    wr(ADDR_STAT, 8'h0F);
    cfg(8'h00, 8'h00);
    cfg(8'h01, 8'h08);
    b = 8'($random(seed));
    wr(ADDR_DATA, b);
    v = 8'($random(seed));
    partner_u.frame(v, 8, 1'h0);
    chk(partner_u.mrx, b);
    rchk(ADDR_DATA, 8'hFF, v);
    cfg(8'h0B, 8'h35);
    cfg(8'h0F, 8'h37);
    cfg(8'h07, 8'h33);
    wr(ADDR_DATA, 8'($random(seed)));
    repeat (20) @(posedge sys_clk);
    partner_u.frame(8'h00, 1, 1'h1);
    rchk(ADDR_CTRL, 8'hFF, 8'h04);
    rchk(ADDR_STAT, 8'h04, 8'h04);
    chk(pins, 8'h03);
    end_of_test();
  end
endmodule
